// [pmc_top.sv]
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_top #(
    parameter int NPER = 16,
    parameter int DIVW = 3,
    parameter int TSU_POSC_CYC = `PMC_CYC(`PMC_TSU_POSC_US),
    parameter int TSU_SOSC_CYC = `PMC_CYC(`PMC_TSU_SOSC_US)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPER-1:0] wake_evt,
    output logic [2:0] osc_sel,
    output logic [DIVW-1:0] pb_div,
    output logic pb_clk_en,
    output logic [NPER-1:0] per_clk_en,
    output pmc_pkg::pmc_ctl_s ctl,
    output logic [1:0] pm_state
);
    localparam int TSU_FAST_RC_CYC =
        `PMC_CYC(`PMC_TSU_FAST_INTERNAL_RC_OSC_US);
    localparam int TSU_LOW_POWER_RC_CYC =
        `PMC_CYC(`PMC_TSU_LOW_POWER_INTERNAL_RC_OSC_US);

    logic [31:0] ctrl_r, pbdiv_r, moden_r, stop_in_idle_ctrl_r, sleeprun_r;
    pmc_pkg::pmc_state_e st_r, st_nxt;
    logic [31:0] dly_r, dly_nxt;
    logic [DIVW-1:0] pbcnt_r;
    logic [2:0] osc_sel_r;
    logic [DIVW-1:0] pb_div_r;
    logic pb_clk_en_r;
    logic [NPER-1:0] per_clk_en_r;
    pmc_pkg::pmc_ctl_s ctl_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    // Access phase completes in two cycles: pready follows penable by one
    wire acc = psel & penable & ~pready_r;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire sel_ctrl = paddr == `PMC_ADDR_CTRL;
    wire sel_pbdiv = paddr == `PMC_ADDR_PBDIV;
    wire sel_moden = paddr == `PMC_ADDR_MODEN;
    wire sel_stop_in_idle_ctrl = paddr == `PMC_ADDR_STOP_IN_IDLE_CTRL;
    wire sel_stat = paddr == `PMC_ADDR_STAT;
    wire sel_srun = paddr == `PMC_ADDR_SLEEPRUN;
    wire mapped = sel_ctrl | sel_pbdiv | sel_moden | sel_stop_in_idle_ctrl
                  | sel_stat | sel_srun;
    wire idle_req = wr & sel_ctrl & pwdata[`PMC_CTRL_IDLE_REQ];
    wire sleep_req = wr & sel_ctrl & pwdata[`PMC_CTRL_SLEEP_REQ];
    wire [2:0] src = ctrl_r[`PMC_CTRL_SRC_LSB +: 3];
    // Enables written with a sleep request must hold from its first cycle
    wire [31:0] ctrl_nxt = (wr & sel_ctrl) ? {26'h0, pwdata[5:0]} : ctrl_r;
    // Only units allowed to run in Sleep and still enabled can wake us from Sleep
    wire wake_hit = |(wake_evt & sleeprun_r[NPER-1:0] & moden_r[NPER-1:0]); // RULE8 RULE9

    logic [31:0] tsu_cyc;
    always_comb begin
        case (src)
            3'h0: tsu_cyc = 32'(TSU_POSC_CYC);
            3'h1, 3'h2: tsu_cyc = 32'(TSU_FAST_RC_CYC);
            3'h3: tsu_cyc = 32'(TSU_SOSC_CYC);
            default: tsu_cyc = 32'(TSU_LOW_POWER_RC_CYC);
        endcase
    end // RULE13

    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_r :
        sel_pbdiv ? pbdiv_r :
        sel_moden ? moden_r :
        sel_stop_in_idle_ctrl ? stop_in_idle_ctrl_r :
        sel_stat ? {30'h0000_0000, st_r} :
        sel_srun ? sleeprun_r : 32'h0000_0000;

    // Mode changes come only from software requests, wake events or the end of the wake delay
    always_comb begin
        st_nxt = st_r;
        dly_nxt = dly_r;
        case (st_r)
            pmc_pkg::PMC_RUN: begin
                if (sleep_req) begin
                    st_nxt = pmc_pkg::PMC_SLEEP; // RULE1
                end else if (idle_req) begin
                    st_nxt = pmc_pkg::PMC_IDLE; // RULE1 RULE5
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (|(wake_evt & moden_r[NPER-1:0])) begin
                    st_nxt = pmc_pkg::PMC_RUN;
                end
            end
            pmc_pkg::PMC_SLEEP: begin
                if (wake_hit) begin
                    st_nxt = pmc_pkg::PMC_WAKE; // RULE17
                    dly_nxt = tsu_cyc;
                end
            end
            pmc_pkg::PMC_WAKE: begin
                if (dly_r <= 32'h0000_0001) begin
                    st_nxt = pmc_pkg::PMC_RUN; // RULE17
                end else begin
                    dly_nxt = dly_r - 32'h0000_0001;
                end
            end
            default: st_nxt = pmc_pkg::PMC_RUN;
        endcase
    end

    wire in_sleep = st_nxt == pmc_pkg::PMC_SLEEP
                    || st_nxt == pmc_pkg::PMC_WAKE;
    wire in_idle = st_nxt == pmc_pkg::PMC_IDLE;
    wire pb_tick = pbcnt_r == pbdiv_r[DIVW-1:0];

    genvar g;
    generate
        for (g = 0; g < NPER; g++) begin : g_per
            wire on = moden_r[g] // RULE15
                & ~(in_idle & stop_in_idle_ctrl_r[g]) // RULE6 RULE16
                & (~in_sleep | sleeprun_r[g]); // RULE7 RULE9
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    per_clk_en_r[g] <= 1'b0;
                end else if (clk_en) begin
                    per_clk_en_r[g] <= on;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= `PMC_RST_CTRL;
            pbdiv_r <= `PMC_RST_PBDIV;
            moden_r <= `PMC_RST_MODEN;
            stop_in_idle_ctrl_r <= `PMC_RST_STOP_IN_IDLE_CTRL;
            sleeprun_r <= `PMC_RST_SLEEPRUN;
            st_r <= pmc_pkg::PMC_RUN;
            dly_r <= 32'h0000_0000;
            pbcnt_r <= '0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            dly_r <= dly_nxt;
            pready_r <= acc;
            pslverr_r <= acc & ~mapped;
            if (rd) begin
                prdata_r <= rd_mux;
            end
            if (wr & sel_ctrl) begin
                // Request bits are pulses, not stored
                ctrl_r <= {26'h0, pwdata[5:0]}; // RULE2
            end
            if (wr & sel_pbdiv) begin
                pbdiv_r <= {{(32 - DIVW){1'b0}}, pwdata[DIVW-1:0]}; // RULE3
            end
            if (wr & sel_moden) begin
                moden_r <= pwdata & {{(32 - NPER){1'b0}}, {NPER{1'b1}}};
            end
            if (wr & sel_stop_in_idle_ctrl) begin
                stop_in_idle_ctrl_r <=
                    pwdata & {{(32 - NPER){1'b0}}, {NPER{1'b1}}};
            end
            if (wr & sel_srun) begin
                sleeprun_r <= pwdata & {{(32 - NPER){1'b0}}, {NPER{1'b1}}};
            end
            pbcnt_r <= pb_tick ? '0 : pbcnt_r + 1'b1; // RULE3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            osc_sel_r <= 3'h0;
            pb_div_r <= '0;
            pb_clk_en_r <= 1'b0;
            ctl_r <= '0;
        end else if (clk_en) begin
            osc_sel_r <= src; // RULE2 RULE5
            pb_div_r <= pbdiv_r[DIVW-1:0];
            pb_clk_en_r <= pb_tick & ~in_sleep; // RULE3 RULE7
            ctl_r.cpu_clk_en <= st_nxt == pmc_pkg::PMC_RUN; // RULE4 RULE17
            ctl_r.sys_osc_en <= st_nxt != pmc_pkg::PMC_SLEEP; // RULE6 RULE7
            ctl_r.cfm_active <=
                ctrl_nxt[`PMC_CTRL_CFM_EN] & ~in_sleep; // RULE10
            ctl_r.bod_active <= ctrl_nxt[`PMC_CTRL_BOD_EN]; // RULE11
            // Pins hold state; no reset is sent to the watchdog on entry
            ctl_r.pin_hold <= in_sleep; // RULE14 RULE12
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign osc_sel = osc_sel_r;
    assign pb_div = pb_div_r;
    assign pb_clk_en = pb_clk_en_r;
    assign per_clk_en = per_clk_en_r;
    assign ctl = ctl_r;
    assign pm_state = st_r;
endmodule

// [pmc_cfg.svh]
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// Contract
// RULE1 - The controller never enters a reduced-power mode unless software asks for it.
// RULE2 - In run modes the processor clock comes from fast RC direct or postscaled, low-power RC or secondary oscillator.
// RULE3 - Peripherals are clocked at a software-programmed fraction of the system clock.
// RULE4 - Idle and Sleep both gate off the processor clock.
// RULE5 - Idle works with any of the four clock sources.
// RULE6 - In Idle the system clock source runs and peripherals stay clocked unless disabled.
// RULE7 - Sleep halts the processor, stops the clock source and every peripheral fed by it.
// RULE8 - Peripherals that stay alive in Sleep can raise a wake event that resumes running.
// RULE9 - Change-detect, watchdog, ADC, UART and externally or low-power-RC clocked units may run in Sleep.
// RULE10 - The clock failure monitor is inactive in Sleep.
// RULE11 - An enabled brown-out detector keeps working through Sleep.
// RULE12 - Entering Sleep does not clear the watchdog count.
// RULE13 - Wake from Sleep may wait a delay that depends on the selected oscillator.
// RULE14 - Output pins keep their levels during Sleep.
// RULE15 - Each module has its own software disable usable before Sleep.
// RULE16 - A stop-in-idle bit of one disables its peripheral in Idle, zero keeps it running.
// RULE17 - On wake the clock source restarts and the processor clock is released after the start-up delay.

`define PMC_ADDR_CTRL 12'h000
`define PMC_ADDR_PBDIV 12'h004
`define PMC_ADDR_MODEN 12'h008
`define PMC_ADDR_STOP_IN_IDLE_CTRL 12'h00C
`define PMC_ADDR_STAT 12'h010
`define PMC_ADDR_SLEEPRUN 12'h014

// CTRL fields
`define PMC_CTRL_SRC_LSB 0
`define PMC_CTRL_BOD_EN 4
`define PMC_CTRL_CFM_EN 5
`define PMC_CTRL_IDLE_REQ 8
`define PMC_CTRL_SLEEP_REQ 9

`define PMC_RST_CTRL 32'h0000_0000
`define PMC_RST_PBDIV 32'h0000_0000
`define PMC_RST_MODEN 32'h0000_FFFF
`define PMC_RST_STOP_IN_IDLE_CTRL 32'h0000_0000
`define PMC_RST_SLEEPRUN 32'h0000_0000

// Oscillator start-up delays in microseconds, per source
`define PMC_CLK_MHZ 25
`define PMC_TSU_POSC_US 1000
`define PMC_TSU_FAST_INTERNAL_RC_OSC_US 10
`define PMC_TSU_SOSC_US 4000
`define PMC_TSU_LOW_POWER_INTERNAL_RC_OSC_US 100
`define PMC_CYC(us) ((us) * `PMC_CLK_MHZ)
`endif

// [pmc_pkg.sv]
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_SRC_POSC = 3'h0,
        PMC_SRC_FAST_INTERNAL_RC_OSC = 3'h1,
        PMC_SRC_FAST_INTERNAL_RC_OSC_DIV = 3'h2,
        PMC_SRC_SOSC = 3'h3,
        PMC_SRC_LOW_POWER_INTERNAL_RC_OSC = 3'h4
    } pmc_src_e;

    typedef enum logic [1:0] {
        PMC_RUN = 2'b00,
        PMC_IDLE = 2'b01,
        PMC_SLEEP = 2'b10,
        PMC_WAKE = 2'b11
    } pmc_state_e;

    typedef struct packed {
        logic cpu_clk_en;
        logic sys_osc_en;
        logic cfm_active;
        logic bod_active;
        logic pin_hold;
    } pmc_ctl_s;
endpackage

// [pmc_top_properties.sv]
`timescale 1ns/1ps
module pmc_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pb_clk_en,
    input wire pmc_pkg::pmc_ctl_s ctl,
    input wire logic [1:0] pm_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire wr_ctrl = psel & penable & pwrite & (paddr == 12'h000);
    property p_ans; psel && penable && !pready |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("apb answer late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_sw; $past(pm_state) == 2'h0 && pm_state != 2'h0 |->
        $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3); endproperty
    a_sw: assert property (p_sw) else $error("mode change unasked");
    property p_halt; pm_state != 2'h0 |-> !ctl.cpu_clk_en; endproperty
    a_halt: assert property (p_halt) else $error("cpu clock on");
    property p_idle; pm_state == 2'h1 |-> ctl.sys_osc_en; endproperty
    a_idle: assert property (p_idle) else $error("osc off in idle");
    property p_slp; pm_state == 2'h2 |-> !ctl.sys_osc_en && !pb_clk_en;
    endproperty
    a_slp: assert property (p_slp) else $error("clock on in sleep");
    property p_cfm; pm_state == 2'h2 |-> !ctl.cfm_active; endproperty
    a_cfm: assert property (p_cfm) else $error("monitor on in sleep");
    property p_bod; pm_state == 2'h2 && $past(pm_state) == 2'h2 |->
        $stable(ctl.bod_active); endproperty
    a_bod: assert property (p_bod) else $error("detector changed");
    property p_wk; pm_state == 2'h3 && $past(pm_state) == 2'h2 |->
        (pm_state == 2'h3)[*8]; endproperty
    a_wk: assert property (p_wk) else $error("wake delay short");
endmodule
bind pmc_top pmc_chk u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .pb_clk_en(pb_clk_en), .ctl(ctl), .pm_state(pm_state));

// [testbench.sv]
`timescale 1ns/1ps
`include "pmc_cfg.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    logic sys_clk = 0;
    logic rst = 1;
    logic clk_en = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [15:0] wake_evt = 0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pb_clk_en, er;
    logic [2:0] osc_sel, pb_div;
    logic [15:0] per_clk_en;
    pmc_pkg::pmc_ctl_s ctl;
    logic [1:0] pm_state;
    int fail_count = 0;
    int n_compared = 0;
    int n;
    localparam int TSU_TB = 20;
    always #20 sys_clk = ~sys_clk;
    pmc_top #(.TSU_POSC_CYC(TSU_TB), .TSU_SOSC_CYC(TSU_TB)) DUT (
        .sys_clk(sys_clk),
        .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_evt(wake_evt),
        .osc_sel(osc_sel), .pb_div(pb_div), .pb_clk_en(pb_clk_en),
        .per_clk_en(per_clk_en), .ctl(ctl), .pm_state(pm_state));
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wst(input logic [1:0] s);
        while (pm_state !== s) begin
            @(posedge sys_clk);
        end
    endtask
    task t_regs;
        for (int i = 0; i < 6; i++) begin
            apb(0, 12'(4 * i), 0);
            `CHK("reset value", (i == 2) ? 32'h0000FFFF : 32'h0, rd)
        end
        apb(0, 12'h020, 0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        apb(1, 12'h008, 32'h0000FFFE);
        @(posedge sys_clk);
        `CHK("module off", 1'b0, per_clk_en[0])
        apb(1, 12'h008, 32'h0000FFFF);
        $display("test regs done");
    endtask
    task t_src;
        for (int s = 4; s >= 0; s--) begin
            apb(1, 12'h000, 32'(s));
            @(posedge sys_clk);
            `CHK("osc_sel", 3'(s), osc_sel)
            `CHK("still run", 2'h0, pm_state)
        end
        $display("test source done");
    endtask
    task t_pbdiv;
        apb(1, 12'h004, 32'h2);
        repeat (2) @(posedge sys_clk);
        n = 0;
        repeat (30) begin
            @(posedge sys_clk);
            n += (pb_clk_en === 1'b1);
        end
        `CHK("pb pulses", 10, n)
        `CHK("pb_div", 3'h2, pb_div)
        $display("test divider done");
    endtask
    task t_idle;
        apb(1, 12'h00C, 32'h1);
        for (int s = 0; s < 5; s++) begin
            apb(1, 12'h000, 32'h100 | s);
            wst(2'h1);
            `CHK("idle", 2'h1, pm_state)
            `CHK("cpu off", 1'b0, ctl.cpu_clk_en)
            `CHK("osc on", 1'b1, ctl.sys_osc_en)
            `CHK("stopped", 1'b0, per_clk_en[0])
            `CHK("kept", 1'b1, per_clk_en[1])
            if (s == 0) begin
                // Clock enable low must hold the mode despite a wake
                clk_en <= 0;
                wake_evt <= 16'h0002;
                repeat (4) @(posedge sys_clk);
                `CHK("frozen", 2'h1, pm_state)
                clk_en <= 1;
            end
            wake_evt <= 16'h0002;
            wst(2'h0);
            wake_evt <= 16'h0;
            @(posedge sys_clk);
            `CHK("cpu back", 1'b1, ctl.cpu_clk_en)
        end
        $display("test idle done");
    endtask
    task t_sleep;
        int w;
        apb(1, 12'h014, 32'h4);
        // Pass 0 wakes on the primary source, pass 1 on the fast RC
        for (int j = 0; j < 2; j++) begin
            apb(1, 12'h000, 32'h230 | j);
            wst(2'h2);
            `CHK("sleep", 2'h2, pm_state)
            `CHK("osc off", 1'b0, ctl.sys_osc_en)
            `CHK("alive", 16'h0004, per_clk_en)
            `CHK("monitor off", 1'b0, ctl.cfm_active)
            `CHK("detector on", 1'b1, ctl.bod_active)
            `CHK("pins held", 1'b1, ctl.pin_hold)
            wake_evt <= 16'h0008;
            repeat (6) @(posedge sys_clk);
            `CHK("no wake", 2'h2, pm_state)
            wake_evt <= 16'h0004;
            wst(2'h3);
            `CHK("waking", 2'h3, pm_state)
            n = 0;
            while (pm_state !== 2'h0 && n < 1000) begin
                @(posedge sys_clk);
                n++;
            end
            wake_evt <= 16'h0;
            w = j ? `PMC_CYC(`PMC_TSU_FAST_INTERNAL_RC_OSC_US) : TSU_TB;
            `CHK("wake len", w, n)
            @(posedge sys_clk);
            `CHK("cpu back", 1'b1, ctl.cpu_clk_en)
            `CHK("monitor back", 1'b1, ctl.cfm_active)
        end
        $display("test sleep done");
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        t_regs;
        t_src;
        t_pbdiv;
        t_idle;
        t_sleep;
        results;
    end
    // Generous span: the longest wait is 250 cycles, far below the 25000-cycle limit
    initial begin
        #1000000;
        fail_count++;
        results;
    end
endmodule
